// ### hw/ep_irq_unit.sv
// Sticky interrupt status, mask and the level interrupt.
`timescale 1ns/1ps
`default_nettype none
module ep_irq_unit (
  input wire logic sys_clk,
  input wire logic reset_n,
  irq_if.unit bus
);
  logic [ep_pkg::FLAG_W-1:0] status_r;
  logic [ep_pkg::FLAG_W-1:0] status_nxt;
  logic [ep_pkg::FLAG_W-1:0] mask_r;
  logic irq_r;

  // An event in the cycle of its clear wins, so nothing is lost.
  genvar i;
  generate
    for (i = 0; i < ep_pkg::FLAG_W; i++) begin : g_stat
      assign status_nxt[i] = bus.ev[i] | (status_r[i] & ~bus.clr[i]);
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= ep_pkg::FLAGS_RST;
      mask_r <= ep_pkg::MASK_RST;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (bus.mask_we) begin
        mask_r <= bus.mask_wd;
      end
      irq_r <= |(status_nxt & (bus.mask_we ? bus.mask_wd : mask_r));
    end
  end

  assign bus.status = status_r;
  assign bus.mask = mask_r;
  assign bus.irq = irq_r;

  a_irq_level_match: assert property (@(posedge sys_clk)
    disable iff (!reset_n) irq_r == |(status_r & mask_r))
    else $error("interrupt level disagrees with status and mask");
endmodule
`default_nettype wire

// ### hw/ep_pkg.sv
// Shared constants for the endpoint status flag block.
`default_nettype none
package ep_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 7;
  localparam int CFG_W = 3;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] ADDR_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0C;

  // Flag positions, shared by the flag, status and mask registers.
  localparam int B_IN_CMP = 0;
  localparam int B_OUT0 = 1;
  localparam int B_SETUP = 2;
  localparam int B_STALL_CRC = 3;
  localparam int B_INRDY = 4;
  localparam int B_STALL_REQ = 5;
  localparam int B_OUT1 = 6;

  // Configuration field positions.
  localparam int C_TYPE_LO = 0;
  localparam int C_TYPE_HI = 1;
  localparam int C_PINGPONG = 2;

  localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h00;
  localparam logic [FLAG_W-1:0] MASK_RST = 7'h00;
  localparam logic [CFG_W-1:0] CFG_RST = 3'h0;

  typedef enum logic [1:0] {
    EP_CONTROL = 2'h0,
    EP_ISO = 2'h1,
    EP_BULK = 2'h2,
    EP_INTR = 2'h3
  } ep_type_e;

  typedef enum logic [1:0] {
    HS_ACK = 2'h0,
    HS_NAK = 2'h1,
    HS_STALL = 2'h2
  } hs_code_e;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### hw/irq_if.sv
// Connection between the flag block and its interrupt unit.
`timescale 1ns/1ps
`default_nettype none
interface irq_if;
  logic [ep_pkg::FLAG_W-1:0] ev;
  logic [ep_pkg::FLAG_W-1:0] clr;
  logic mask_we;
  logic [ep_pkg::FLAG_W-1:0] mask_wd;
  logic [ep_pkg::FLAG_W-1:0] status;
  logic [ep_pkg::FLAG_W-1:0] mask;
  logic irq;
  modport unit (input ev, clr, mask_we, mask_wd,
    output status, mask, irq);
  modport owner (output ev, clr, mask_we, mask_wd,
    input status, mask, irq);
endinterface
`default_nettype wire

// ### hw/usb_ep_flags.sv
// Endpoint handshake and status flags with an AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// RL1 - Stall request set answers next handshake with STALL.
// RL2 - Valid SETUP clears stall request on control.
// RL3 - Sent STALL sets stall-sent flag, interrupt. On isochronous endpoints the code ignores a sent STALL.
// RL4 - Isochronous: flag shows CRC error, read-only.
// RL5 - SETUP sets its flag, clears others, interrupt. On isochronous endpoints the code keeps the CRC flag.
// RL6 - Firmware clears setup flag after reading data.
// RL7 - OUT stored in bank 0 sets flag, interrupt.
// RL8 - Bank 0 flag set NAKs OUT, except isochronous.
// RL9 - Control: early SETUP may overwrite held bank.
// RL10 - Firmware clears OUT flag after reading data.
// RL11 - IN sent or ACKed sets complete flag, interrupt.
// RL12 - Firmware clears complete flag before next ready.
// RL13 - Ready set by firmware, cleared after send/ACK.
// RL14 - Ping-pong bank 1 flag sets, NAKs until cleared. On isochronous endpoints the code does not NAK it.
module usb_ep_flags (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ep_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ep_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ep_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ep_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic setup_rx,
  input wire logic out_rx,
  input wire logic out_bank,
  input wire logic crc_err,
  input wire logic in_done,
  input wire logic stall_done,
  input wire logic hs_req,
  input wire logic hs_is_out,
  input wire logic hs_bank,
  output logic hs_valid,
  output logic [1:0] hs_code,
  output logic in_ready,
  output logic irq
);
  logic aw_full_r;
  logic w_full_r;
  logic [ep_pkg::ADDR_W-1:0] awaddr_r;
  logic [ep_pkg::DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [ep_pkg::FLAG_W-1:0] flags_r;
  logic [ep_pkg::FLAG_W-1:0] flags_nxt;
  logic [ep_pkg::CFG_W-1:0] cfg_r;

  irq_if irqc ();

  ep_irq_unit u_irq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .bus(irqc.unit)
  );

  // Write path: address and data are caught separately, then applied.
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire b_done = s_axi_bvalid & s_axi_bready;
  wire lane0 = wstrb_r[0];
  wire wa_cfg = awaddr_r == ep_pkg::ADDR_CFG;
  wire wa_flags = awaddr_r == ep_pkg::ADDR_FLAGS;
  wire wa_stat = awaddr_r == ep_pkg::ADDR_IRQ_STAT;
  wire wa_mask = awaddr_r == ep_pkg::ADDR_IRQ_MASK;
  wire wa_hit = wa_cfg | wa_flags | wa_stat | wa_mask;
  wire wr_cfg = wr_fire & wa_cfg & lane0;
  wire wr_flags = wr_fire & wa_flags & lane0;
  wire [ep_pkg::FLAG_W-1:0] wd = wdata_r[ep_pkg::FLAG_W-1:0];
  // Hardware-set flags are cleared by writing zero to their bit, except the CRC flag on isochronous endpoints.
  wire [ep_pkg::FLAG_W-1:0] fw_clr = wr_flags ? ~wd : '0;

  // Read path decode.
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_done = s_axi_rvalid & s_axi_rready;
  wire ra_cfg = s_axi_araddr == ep_pkg::ADDR_CFG;
  wire ra_flags = s_axi_araddr == ep_pkg::ADDR_FLAGS;
  wire ra_stat = s_axi_araddr == ep_pkg::ADDR_IRQ_STAT;
  wire ra_mask = s_axi_araddr == ep_pkg::ADDR_IRQ_MASK;
  wire ra_hit = ra_cfg | ra_flags | ra_stat | ra_mask;
  wire [ep_pkg::DATA_W-1:0] rd_word =
    ra_cfg ? ep_pkg::DATA_W'(cfg_r) :
    ra_flags ? ep_pkg::DATA_W'(flags_r) :
    ra_stat ? ep_pkg::DATA_W'(irqc.status) :
    ra_mask ? ep_pkg::DATA_W'(irqc.mask) : '0;

  // Endpoint configuration.
  wire [1:0] ep_type = cfg_r[ep_pkg::C_TYPE_HI:ep_pkg::C_TYPE_LO];
  wire is_iso = ep_type == ep_pkg::EP_ISO;
  wire is_ctrl = ep_type == ep_pkg::EP_CONTROL;
  wire pingpong = cfg_r[ep_pkg::C_PINGPONG];

  wire out0_in = out_rx & ~out_bank;
  wire out1_in = out_rx & out_bank & pingpong;
  wire stall_ev = stall_done & ~is_iso;

  // A valid SETUP wipes every other flag, stall request included, except the CRC flag on isochronous endpoints.
  assign flags_nxt[ep_pkg::B_SETUP] = setup_rx |
    (flags_r[ep_pkg::B_SETUP] & ~fw_clr[ep_pkg::B_SETUP]); // RL5
  assign flags_nxt[ep_pkg::B_STALL_REQ] = setup_rx ? 1'b0 : // RL2
    wr_flags ? wd[ep_pkg::B_STALL_REQ] :
    flags_r[ep_pkg::B_STALL_REQ];
  // Firmware arming in the same cycle as a completion keeps the arm.
  assign flags_nxt[ep_pkg::B_INRDY] = setup_rx ? 1'b0 :
    wr_flags ? wd[ep_pkg::B_INRDY] :
    in_done ? 1'b0 : flags_r[ep_pkg::B_INRDY]; // RL13
  assign flags_nxt[ep_pkg::B_IN_CMP] = ~setup_rx & (in_done |
    (flags_r[ep_pkg::B_IN_CMP] & ~fw_clr[ep_pkg::B_IN_CMP])); // RL11
  assign flags_nxt[ep_pkg::B_OUT0] = ~setup_rx & (out0_in |
    (flags_r[ep_pkg::B_OUT0] & ~fw_clr[ep_pkg::B_OUT0])); // RL7
  assign flags_nxt[ep_pkg::B_OUT1] = ~setup_rx & (out1_in |
    (flags_r[ep_pkg::B_OUT1] & ~fw_clr[ep_pkg::B_OUT1])); // RL14
  // On isochronous endpoints the bit tracks each reception only.
  assign flags_nxt[ep_pkg::B_STALL_CRC] = is_iso ?
    (out_rx ? crc_err : flags_r[ep_pkg::B_STALL_CRC]) : // RL4
    ~setup_rx & (stall_ev |
    (flags_r[ep_pkg::B_STALL_CRC] & ~fw_clr[ep_pkg::B_STALL_CRC])); // RL3

  // Interrupt events share the flag layout.
  assign irqc.ev[ep_pkg::B_IN_CMP] = in_done & ~setup_rx; // RL11
  assign irqc.ev[ep_pkg::B_OUT0] = out0_in & ~setup_rx; // RL7
  assign irqc.ev[ep_pkg::B_SETUP] = setup_rx; // RL5
  assign irqc.ev[ep_pkg::B_STALL_CRC] = stall_ev & ~setup_rx; // RL3
  assign irqc.ev[ep_pkg::B_INRDY] = 1'b0;
  assign irqc.ev[ep_pkg::B_STALL_REQ] = 1'b0;
  assign irqc.ev[ep_pkg::B_OUT1] = out1_in & ~setup_rx; // RL14
  assign irqc.clr = (wr_fire & wa_stat & lane0) ? wd : '0;
  assign irqc.mask_we = wr_fire & wa_mask & lane0;
  assign irqc.mask_wd = wd;

  // Handshake choice; SETUP never passes through here, so a held
  // bank never blocks it.
  wire nak_out = ~is_iso & ((~hs_bank & flags_r[ep_pkg::B_OUT0]) |
    (hs_bank & pingpong & flags_r[ep_pkg::B_OUT1])); // RL8 RL14 RL9
  wire nak_in = ~flags_r[ep_pkg::B_INRDY];
  wire [1:0] hs_pick =
    flags_r[ep_pkg::B_STALL_REQ] ? ep_pkg::HS_STALL : // RL1
    (hs_is_out ? nak_out : nak_in) ? ep_pkg::HS_NAK :
    ep_pkg::HS_ACK;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_r <= ep_pkg::FLAGS_RST;
      cfg_r <= ep_pkg::CFG_RST;
    end else begin
      flags_r <= flags_nxt;
      if (wr_cfg) begin
        cfg_r <= wdata_r[ep_pkg::CFG_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hs_valid <= 1'b0;
      hs_code <= ep_pkg::HS_ACK;
      in_ready <= 1'b0;
      irq <= 1'b0;
    end else begin
      hs_valid <= hs_req;
      if (hs_req) begin
        hs_code <= hs_pick;
      end
      in_ready <= flags_nxt[ep_pkg::B_INRDY];
      irq <= irqc.irq;
    end
  end

  // The ready lines drop while a word is held, so a second write
  // waits until the response has been taken.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (b_done) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ep_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wa_hit ? ep_pkg::RESP_OKAY : ep_pkg::RESP_SLVERR;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ep_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= ra_hit ? ep_pkg::RESP_OKAY : ep_pkg::RESP_SLVERR;
    end else if (r_done) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_in_sent;
    in_done && !setup_rx && !wr_flags;
  endsequence

  sequence s_stall_answer;
    hs_req && flags_r[ep_pkg::B_STALL_REQ];
  endsequence

  a_stall_answer_given: assert property ( // RL1
    s_stall_answer |=> hs_valid && hs_code == ep_pkg::HS_STALL)
    else $error("stall request not answered with STALL");

  a_setup_stall_clear: assert property ( // RL2
    setup_rx && is_ctrl |=> !flags_r[ep_pkg::B_STALL_REQ])
    else $error("SETUP left the stall request set");

  a_stall_sent_flag: assert property ( // RL3
    stall_done && !is_iso && !setup_rx
    |=> flags_r[ep_pkg::B_STALL_CRC] && irqc.status[ep_pkg::B_STALL_CRC])
    else $error("sent STALL not flagged");

  a_iso_crc_follow: assert property ( // RL4
    out_rx && is_iso && !wr_cfg
    |=> flags_r[ep_pkg::B_STALL_CRC] == $past(crc_err))
    else $error("isochronous CRC flag not refreshed");

  a_setup_wipes_rest: assert property ( // RL5
    setup_rx |=> flags_r == (ep_pkg::FLAG_W'(1) << ep_pkg::B_SETUP)
      ##1 irqc.status[ep_pkg::B_SETUP] || $past(irqc.clr[ep_pkg::B_SETUP]))
    else $error("SETUP did not set its flag alone");

  a_out0_stored: assert property ( // RL7
    out0_in && !setup_rx |=> flags_r[ep_pkg::B_OUT0])
    else $error("bank 0 reception not flagged");

  a_out0_nak: assert property ( // RL8
    hs_req && hs_is_out && !hs_bank && !is_iso
      && flags_r[ep_pkg::B_OUT0] && !flags_r[ep_pkg::B_STALL_REQ]
    |=> hs_code == ep_pkg::HS_NAK)
    else $error("held bank 0 not NAKed");

  a_in_complete: assert property ( // RL11 RL13
    s_in_sent |=> flags_r[ep_pkg::B_IN_CMP] && !flags_r[ep_pkg::B_INRDY]
      && !in_ready)
    else $error("IN completion not reflected in flags");

  a_bank1_nak: assert property ( // RL14
    hs_req && hs_is_out && hs_bank && pingpong && !is_iso
      && flags_r[ep_pkg::B_OUT1] && !flags_r[ep_pkg::B_STALL_REQ]
    |=> hs_code == ep_pkg::HS_NAK)
    else $error("held bank 1 not NAKed");

  // Mask as the unit applies it to an event: a mask write in the same
  // cycle counts at once.
  wire [ep_pkg::FLAG_W-1:0] mask_eff =
    irqc.mask_we ? irqc.mask_wd : irqc.mask;

  // The pin trails its event by two edges: unit flop, then pin flop.
  sequence s_irq_late;
    ##1 irq;
  endsequence

  a_out0_irq_raise: assert property ( // RL7
    irqc.ev[ep_pkg::B_OUT0] && mask_eff[ep_pkg::B_OUT0] |=> s_irq_late)
    else $error("bank 0 reception raised no interrupt");

  a_done_irq_raise: assert property ( // RL11
    irqc.ev[ep_pkg::B_IN_CMP] && mask_eff[ep_pkg::B_IN_CMP] |=> s_irq_late)
    else $error("IN completion raised no interrupt");

  a_stall_irq_raise: assert property ( // RL3
    irqc.ev[ep_pkg::B_STALL_CRC] && mask_eff[ep_pkg::B_STALL_CRC]
    |=> s_irq_late)
    else $error("sent STALL raised no interrupt");

  a_setup_irq_raise: assert property ( // RL5
    irqc.ev[ep_pkg::B_SETUP] && mask_eff[ep_pkg::B_SETUP] |=> s_irq_late)
    else $error("SETUP raised no interrupt");

  a_bank1_irq_raise: assert property ( // RL14
    irqc.ev[ep_pkg::B_OUT1] && mask_eff[ep_pkg::B_OUT1] |=> s_irq_late)
    else $error("bank 1 reception raised no interrupt");

  a_early_setup_over: assert property ( // RL9
    setup_rx && is_ctrl && flags_r[ep_pkg::B_OUT0]
    |=> flags_r[ep_pkg::B_SETUP] && !flags_r[ep_pkg::B_OUT0])
    else $error("held bank 0 blocked an early SETUP");

  a_ready_arm_copy: assert property ( // RL13
    wr_flags && wd[ep_pkg::B_INRDY] && !setup_rx
    |=> flags_r[ep_pkg::B_INRDY] && in_ready)
    else $error("firmware arming not shown on the ready pin");

  a_hs_code_hold: assert property ( // RL1
    !hs_req |=> $stable(hs_code))
    else $error("handshake code changed without a token");

  a_write_ready_low: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while a response is pending");

  a_read_ready_low: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while read data is pending");
endmodule
`default_nettype wire

// ### tb/test_usb_ep_flags.sv
// Self-checking bench for the endpoint status flag block.
`timescale 1ns/1ps
`default_nettype none
module test_usb_ep_flags;
  localparam logic [1:0] OK = ep_pkg::RESP_OKAY;
  localparam logic [1:0] ER = ep_pkg::RESP_SLVERR;
  localparam logic [7:0] CF = ep_pkg::ADDR_CFG;
  localparam logic [7:0] FL = ep_pkg::ADDR_FLAGS;
  localparam logic [7:0] ST = ep_pkg::ADDR_IRQ_STAT;
  localparam logic [7:0] MK = ep_pkg::ADDR_IRQ_MASK;
  localparam logic [3:0] E_SET = 4'h8;
  localparam logic [3:0] E_OUT = 4'h4;
  localparam logic [3:0] E_IN = 4'h2;
  localparam logic [3:0] E_STL = 4'h1;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, in_ready;
  logic [1:0] bresp, rresp, hs_code;
  logic [31:0] rdata;
  logic [2:0] ans;
  logic setup_rx, out_rx, out_bank, crc_err, in_done, stall_done;
  logic hs_req, hs_is_out, hs_bank, hs_valid;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;

  usb_ep_flags u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .setup_rx(setup_rx), .out_rx(out_rx),
    .out_bank(out_bank), .crc_err(crc_err), .in_done(in_done),
    .stall_done(stall_done), .hs_req(hs_req), .hs_is_out(hs_is_out),
    .hs_bank(hs_bank), .hs_valid(hs_valid), .hs_code(hs_code),
    .in_ready(in_ready), .irq(irq)
  );
  usb_host_model u_host (
    .sys_clk(sys_clk), .hs_valid(hs_valid), .hs_code(hs_code),
    .setup_rx(setup_rx), .out_rx(out_rx), .out_bank(out_bank),
    .crc_err(crc_err), .in_done(in_done), .stall_done(stall_done),
    .hs_req(hs_req), .hs_is_out(hs_is_out), .hs_bank(hs_bank)
  );

  always #4 sys_clk = ~sys_clk;

  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The whole sequence needs about two hundred cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_sig(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [6:0] d,
      input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {25'h0000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_sig({1'b0, bresp}, {1'b0, er});
    chk_sig({1'b0, awready, wready}, 3'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [6:0] ed,
      input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk_reg(rdata, {25'h0000000, ed});
    chk_sig({1'b0, rresp}, {1'b0, er});
    chk_sig({2'h0, arready}, 3'h0);
  endtask

  task automatic tok(input logic o, input logic b, input logic [1:0] ec);
    u_host.token(o, b, ans);
    chk_sig(ans, {1'b1, ec});
  endtask

  // Two edges let the interrupt and ready copies settle after an event.
  task automatic pins(input logic e_irq, input logic e_rdy);
    repeat (2) @(posedge sys_clk);
    #1;
    chk_sig({1'b0, irq, in_ready}, {1'b0, e_irq, e_rdy});
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(CF, 7'h00, OK);
    rd(FL, 7'h00, OK);
    rd(ST, 7'h00, OK);
    rd(MK, 7'h00, OK);
    rd(8'h10, 7'h00, ER);
    wr(8'h10, 7'h7F, ER);
    wr(MK, 7'h4F, OK);
    rd(MK, 7'h4F, OK);
    u_host.event_pulse(E_OUT, 1'b0, 1'b0);
    rd(FL, 7'h02, OK);
    pins(1'b1, 1'b0);
    tok(1'b1, 1'b0, ep_pkg::HS_NAK);
    wr(FL, 7'h4D, OK);
    tok(1'b1, 1'b0, ep_pkg::HS_ACK);
    wr(ST, 7'h7F, OK);
    pins(1'b0, 1'b0);
    u_host.event_pulse(E_OUT, 1'b0, 1'b0);
    wr(ST, 7'h7F, OK);
    wr(FL, 7'h6F, OK);
    tok(1'b0, 1'b0, ep_pkg::HS_STALL);
    tok(1'b1, 1'b0, ep_pkg::HS_STALL);
    u_host.event_pulse(E_STL, 1'b0, 1'b0);
    rd(FL, 7'h2A, OK);
    pins(1'b1, 1'b0);
    wr(ST, 7'h7F, OK);
    u_host.event_pulse(E_SET, 1'b0, 1'b0);
    rd(FL, 7'h04, OK);
    pins(1'b1, 1'b0);
    tok(1'b0, 1'b0, ep_pkg::HS_NAK);
    wr(FL, 7'h4B, OK);
    rd(FL, 7'h00, OK);
    wr(ST, 7'h7F, OK);
    wr(FL, 7'h5F, OK);
    pins(1'b0, 1'b1);
    tok(1'b0, 1'b0, ep_pkg::HS_ACK);
    u_host.event_pulse(E_IN, 1'b0, 1'b0);
    rd(FL, 7'h01, OK);
    pins(1'b1, 1'b0);
    wr(FL, 7'h4E, OK);
    wr(ST, 7'h7F, OK);
    rd(ST, 7'h00, OK);
    wr(CF, 7'h01, OK);
    u_host.event_pulse(E_OUT, 1'b0, 1'b1);
    rd(FL, 7'h0A, OK);
    tok(1'b1, 1'b0, ep_pkg::HS_ACK);
    wr(FL, 7'h47, OK);
    rd(FL, 7'h0A, OK);
    u_host.event_pulse(E_OUT, 1'b0, 1'b0);
    rd(FL, 7'h02, OK);
    wr(FL, 7'h00, OK);
    wr(CF, 7'h06, OK);
    wr(ST, 7'h7F, OK);
    u_host.event_pulse(E_OUT, 1'b1, 1'b0);
    rd(FL, 7'h40, OK);
    tok(1'b1, 1'b1, ep_pkg::HS_NAK);
    tok(1'b1, 1'b0, ep_pkg::HS_ACK);
    pins(1'b1, 1'b0);
    wr(MK, 7'h00, OK);
    pins(1'b0, 1'b0);
    wr(FL, 7'h0F, OK);
    tok(1'b1, 1'b1, ep_pkg::HS_ACK);
    wr(CF, 7'h03, OK);
    wr(FL, 7'h20, OK);
    tok(1'b0, 1'b0, ep_pkg::HS_STALL);
    u_host.event_pulse(E_STL, 1'b0, 1'b0);
    rd(FL, 7'h28, OK);
    conclude();
  end
endmodule
`default_nettype wire

// ### tb/usb_host_model.sv
// Behavioural USB host that drives link events and handshake tokens.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input wire logic sys_clk,
  input wire logic hs_valid,
  input wire logic [1:0] hs_code,
  output logic setup_rx,
  output logic out_rx,
  output logic out_bank,
  output logic crc_err,
  output logic in_done,
  output logic stall_done,
  output logic hs_req,
  output logic hs_is_out,
  output logic hs_bank
);
  initial begin
    {setup_rx, out_rx, in_done, stall_done, hs_req} = 5'h00;
    {out_bank, crc_err, hs_is_out, hs_bank} = 4'h0;
  end
  // Qualifiers flip when released so the design cannot lean on stale values.
  task automatic event_pulse(input logic [3:0] ev, input logic bank,
      input logic crc);
    @(posedge sys_clk);
    {setup_rx, out_rx, in_done, stall_done} <= ev;
    out_bank <= bank;
    crc_err <= crc;
    @(posedge sys_clk);
    {setup_rx, out_rx, in_done, stall_done} <= 4'h0;
    out_bank <= ~bank;
    crc_err <= ~crc;
  endtask
  task automatic token(input logic is_out, input logic bank,
      output logic [2:0] ans);
    @(posedge sys_clk);
    hs_req <= 1'b1;
    hs_is_out <= is_out;
    hs_bank <= bank;
    @(posedge sys_clk);
    hs_req <= 1'b0;
    hs_is_out <= ~is_out;
    hs_bank <= ~bank;
    #1;
    ans = {hs_valid, hs_code};
  endtask
endmodule
`default_nettype wire
